/* rtl/nvm_byte_ctrl.sv */
// Byte program, byte read and chip erase controller for the nonvolatile array
`timescale 1ns/1ps
module nvm_byte_ctrl
  import nvm_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mode_wr,
  input wire logic [7:0] mode_wdata,
  output logic [7:0] nvm_mode_ctrl,
  output logic busy,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  input wire logic nvm_store_instr,
  input wire logic nvm_load_instr,
  input wire logic [ADDR_W-1:0] nvm_address_var,
  output logic read_valid
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PROG = 4'b0010,
    S_ERASE = 4'b0100,
    S_READ = 4'b1000
  } state_e;

  // Copies of the operation lengths for the cycle delays in the checks below
  localparam int PROG_SPAN = PROG_CYC;
  localparam int ERASE_SPAN = ERASE_CYC;

  // Counter load for an operation that lasts the given number of cycles
  function automatic logic [CNT_W-1:0] span_to_count(input int span);
    return CNT_W'(span - 1);
  endfunction

  state_e state_q, state_d;
  logic [7:0] mode_q;
  logic [7:0] data_q;
  logic [7:0] mem_q [DEPTH];
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [IDX_W-1:0] addr_q;
  logic [7:0] wbyte_q;

  wire byte_armed = (mode_q == MODE_BYTE);
  wire erase_armed = (mode_q == MODE_ERASE);
  wire idle = (state_q == S_IDLE);
  // Unrecognised codes leave array and data register alone
  wire go_prog = idle && nvm_store_instr && byte_armed;
  wire go_erase = idle && nvm_store_instr && erase_armed;
  wire go_read = idle && nvm_load_instr && byte_armed;
  wire [IDX_W-1:0] idx = nvm_address_var[IDX_W-1:0];
  wire cnt_done = (cnt_q == '0);
  wire prog_fire = (state_q == S_PROG) && cnt_done;
  wire erase_fire = (state_q == S_ERASE) && cnt_done;
  wire read_fire = (state_q == S_READ) && cnt_done;
  // Data strobes are refused while any operation runs, mode strobes only during program or erase
  wire mode_take = mode_wr && !busy;
  wire data_take = data_wr && idle;

  // Busy covers program and erase only; a read shows as read_valid low
  assign nvm_mode_ctrl = mode_q;
  assign busy = (state_q == S_PROG) || (state_q == S_ERASE);
  assign data_rdata = data_q;
  assign read_valid = idle;

  // One operation at a time; the counter holds the cycles still to run after the current one
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      S_IDLE: begin
        if (go_prog) begin
          state_d = S_PROG;
          cnt_d = span_to_count(PROG_CYC);
        end else if (go_erase) begin
          state_d = S_ERASE;
          cnt_d = span_to_count(ERASE_CYC);
        end else if (go_read) begin
          state_d = S_READ;
          cnt_d = span_to_count(READ_LAT);
        end
      end
      S_PROG, S_ERASE, S_READ: begin
        if (cnt_done) begin
          state_d = S_IDLE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      mode_q <= MODE_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (mode_take) begin
        mode_q <= mode_wdata;
      end
    end
  end

  // Operand and byte are latched when a program or read is taken
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_q <= '0;
      wbyte_q <= DATA_RESET;
    end else if (go_prog || go_read) begin
      addr_q <= idx;
      wbyte_q <= data_q;
    end
  end

  // Data register: software write, or read result; held otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_q <= DATA_RESET;
    end else if (read_fire) begin
      data_q <= mem_q[addr_q];
    end else if (data_take) begin
      data_q <= data_wdata;
    end
  end

  // Array storage; no ordinary data path reaches it
  always_ff @(posedge clock) begin
    if (erase_fire) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= ERASED_BYTE;
      end
    end else if (prog_fire) begin
      mem_q[addr_q] <= wbyte_q;
    end
  end

  // Every array location at the erased value, for the whole-array check
  logic all_erased;
  always_comb begin
    all_erased = 1'b1;
    for (int i = 0; i < DEPTH; i++) begin
      if (mem_q[i] != ERASED_BYTE) begin
        all_erased = 1'b0;
      end
    end
  end

  // Checks on the design's own outputs and state
  a_busy_prog: assert property (@(posedge clock) disable iff (!rst_n)
    go_prog |=> busy [*2]) else $error("busy not held during program");
  a_erase_busy: assert property (@(posedge clock) disable iff (!rst_n)
    go_erase |=> busy ##[0:60] !busy) else $error("erase busy wrong");
  a_read_two: assert property (@(posedge clock) disable iff (!rst_n)
    go_read |=> !read_valid ##1 !read_valid ##1 read_valid)
    else $error("read latency not two");
  a_read_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (idle && !data_wr && !go_read) |=> $stable(data_rdata))
    else $error("data register changed");
  a_ignore_bad: assert property (@(posedge clock) disable iff (!rst_n)
    (idle && !byte_armed && !erase_armed) |=> idle) else $error("bad code acted");
  a_erase_ones: assert property (@(posedge clock) disable iff (!rst_n)
    erase_fire |=> mem_q[idx] == ERASED_BYTE) else $error("erase not ones");
  a_prog_write: assert property (@(posedge clock) disable iff (!rst_n)
    prog_fire |=> mem_q[$past(addr_q)] == $past(wbyte_q)) else $error("byte not written");
  a_no_busy_read: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == S_READ) |-> !busy) else $error("busy during read");

  // Operation lengths, whole-array erase and one-hot state
  a_prog_span: assert property (@(posedge clock) disable iff (!rst_n)
    go_prog |-> ##PROG_SPAN busy ##1 !busy)
    else $error("program length wrong");
  a_erase_span: assert property (@(posedge clock) disable iff (!rst_n)
    go_erase |-> ##ERASE_SPAN busy ##1 !busy)
    else $error("erase length wrong");
  a_erase_whole: assert property (@(posedge clock) disable iff (!rst_n)
    erase_fire |=> all_erased)
    else $error("erase left bytes behind");
  a_state_legal: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot(state_q))
    else $error("state not one-hot");

  // Register loads
  a_mode_written: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_wr && !busy) |=> (nvm_mode_ctrl == $past(mode_wdata)))
    else $error("mode code not taken");
  a_data_written: assert property (@(posedge clock) disable iff (!rst_n)
    (data_wr && idle) |=> (data_rdata == $past(data_wdata)))
    else $error("data byte not taken");
  a_store_data: assert property (@(posedge clock) disable iff (!rst_n)
    go_prog |=> (wbyte_q == $past(data_rdata)))
    else $error("program byte not latched");
  a_addr_low: assert property (@(posedge clock) disable iff (!rst_n)
    (go_prog || go_read) |=> (addr_q == $past(idx)))
    else $error("operand not latched");
  a_read_result: assert property (@(posedge clock) disable iff (!rst_n)
    read_fire |=> (data_rdata == $past(mem_q[addr_q])))
    else $error("read byte wrong");

  // Refused strobes and instructions
  a_mode_locked: assert property (@(posedge clock) disable iff (!rst_n)
    (busy && mode_wr) |=> $stable(nvm_mode_ctrl))
    else $error("mode changed while busy");
  a_data_locked: assert property (@(posedge clock) disable iff (!rst_n)
    (!idle && !read_fire) |=> $stable(data_rdata))
    else $error("data changed mid operation");
  a_bad_no_busy: assert property (@(posedge clock) disable iff (!rst_n)
    (idle && nvm_store_instr && !byte_armed && !erase_armed) |=> !busy)
    else $error("bad code started work");
  a_bad_load: assert property (@(posedge clock) disable iff (!rst_n)
    (idle && nvm_load_instr && !nvm_store_instr && !byte_armed) |=> idle)
    else $error("load taken without byte mode");

  // Main scenarios
  c_prog: cover property (@(posedge clock) disable iff (!rst_n) go_prog);
  c_erase: cover property (@(posedge clock) disable iff (!rst_n) go_erase);
  c_read: cover property (@(posedge clock) disable iff (!rst_n) read_fire);
  c_bad_store: cover property (@(posedge clock) disable iff (!rst_n)
    idle && nvm_store_instr && !byte_armed && !erase_armed);
  c_mode_locked: cover property (@(posedge clock) disable iff (!rst_n)
    busy && mode_wr);
endmodule // nvm_byte_ctrl

/* rtl/nvm_ctrl_pkg.sv */
// Package of constants for the byte-wide nonvolatile access controller
// Behaviour
// - Code 0x5A arms byte program (no erase) and byte read
// - Store programs data register byte at operand
// - Busy flag high during program or erase
// - Load fills data register after two cycles
// - Read byte held until next load or data write
// - Code 0xA5 arms erase via store
// - Chip erase clears the whole array unless a reset aborts it before it completes
// - Erased bytes read back as all ones
// - Array reachable only via store/load instructions
package nvm_ctrl_pkg;
  localparam int ADDR_W = 16;
  localparam int DEPTH = 256;
  localparam int IDX_W = 8;
  localparam logic [7:0] MODE_BYTE = 8'h5A;
  localparam logic [7:0] MODE_ERASE = 8'hA5;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Timing in nanoseconds at the 10 ns clock
  localparam int CLK_NS = 10;
  localparam int PROG_NS = 200;
  localparam int ERASE_NS = 400;
  localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_LAT = 2;
  localparam int CNT_W = 8;
endpackage

/* test/nvm_core_model.sv */
// Core model issuing data, mode codes and store or load instructions
`timescale 1ns/1ps
module nvm_core_model (
  input wire logic clock,
  input wire logic busy,
  input wire logic read_valid,
  output logic mode_wr,
  output logic [7:0] mode_wdata,
  output logic data_wr,
  output logic [7:0] data_wdata,
  output logic nvm_store_instr,
  output logic nvm_load_instr,
  output logic [15:0] nvm_address_var
);
  initial {mode_wr, mode_wdata, data_wr, data_wdata, nvm_store_instr} = '0;
  initial {nvm_load_instr, nvm_address_var} = '0;
  task automatic launch(input logic [7:0] m, d, input logic [15:0] a, input logic ld);
    @(negedge clock) {data_wr, data_wdata} = {1'b1, d};
    @(negedge clock) {data_wr, mode_wr, mode_wdata} = {2'b01, m};
    @(negedge clock) {mode_wr, nvm_store_instr, nvm_load_instr} = {1'b0, !ld, ld};
    nvm_address_var = a;
    @(negedge clock) {nvm_store_instr, nvm_load_instr} = 2'b00;
  endtask
  // Poll busy and read_valid, then move the operand away
  task automatic settle();
    repeat (3) @(negedge clock);
    for (int i = 0; i < 60 && (busy || !read_valid); i++) @(negedge clock);
    nvm_address_var = ~nvm_address_var;
  endtask
  task automatic op(input logic [7:0] m, d, input logic [15:0] a, input logic ld);
    launch(m, d, a, ld);
    settle();
  endtask
  // One-cycle mode and data strobes, for requests that must be refused
  task automatic strobe(input logic mw, dw, input logic [7:0] v);
    @(negedge clock) {mode_wr, mode_wdata, data_wr, data_wdata} = {mw, v, dw, v};
    @(negedge clock) {mode_wr, data_wr} = 2'b00;
  endtask
endmodule // nvm_core_model

/* test/test_nvm_byte_ctrl.sv */
// Self-checking bench for the nonvolatile byte access controller
`timescale 1ns/1ps
module test_nvm_byte_ctrl;
  import nvm_ctrl_pkg::*;
  logic clock = 0;
  logic rst_n = 0;
  logic mode_wr, data_wr, nvm_store_instr, nvm_load_instr, busy, read_valid;
  logic [7:0] mode_wdata, data_wdata, nvm_mode_ctrl, data_rdata;
  logic [15:0] nvm_address_var;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int nb = 0;
  // Program address, byte, read address, expected byte
  logic [47:0] rows [4] = '{48'h0000_11_0000_11, 48'h00FF_A5_00FF_A5,
    48'h0100_3C_0000_3C, 48'h0001_00_00FF_A5};
  always #5 clock = ~clock;
  always @(posedge clock) nb <= nb + busy;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  nvm_core_model core (.clock, .busy, .read_valid, .mode_wr, .mode_wdata, .data_wr,
    .data_wdata, .nvm_store_instr, .nvm_load_instr, .nvm_address_var);
  nvm_byte_ctrl dut (.clock, .rst_n, .mode_wr, .mode_wdata, .nvm_mode_ctrl, .busy, .data_wr,
    .data_wdata, .data_rdata, .nvm_store_instr, .nvm_load_instr, .nvm_address_var,
    .read_valid);
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    core.op(MODE_BYTE, ~e, a, 1'b1);
    chk(data_rdata, e);
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    chk(nvm_mode_ctrl, MODE_RESET);
    chk(data_rdata, DATA_RESET);
    chk({6'h00, busy, read_valid}, 8'h01);
    rst_n = 1;
    foreach (rows[i]) begin
      nb = 0;
      core.op(MODE_BYTE, rows[i][31:24], rows[i][47:32], 1'b0);
      chk(8'(nb), 8'(PROG_CYC));
      chk(nvm_mode_ctrl, MODE_BYTE);
      rd(rows[i][23:8], rows[i][7:0]);
    end
    repeat (5) @(negedge clock);
    chk(data_rdata, 8'hA5);
    nb = 0;
    core.op(MODE_ERASE, 8'h00, 16'h0000, 1'b0);
    chk(8'(nb), 8'(ERASE_CYC));
    rd(16'h0000, ERASED_BYTE);
    rd(16'h00FF, ERASED_BYTE);
    nb = 0;
    core.op(8'h00, 8'h12, 16'h0010, 1'b0);
    chk(8'(nb), 8'h00);
    chk(data_rdata, 8'h12);
    core.op(8'h33, 8'h44, 16'h0010, 1'b1);
    chk(data_rdata, 8'h44);
    chk(nvm_mode_ctrl, 8'h33);
    rd(16'h0010, ERASED_BYTE);
    // Strobes while busy are dropped; the program keeps its byte
    core.launch(MODE_BYTE, 8'h66, 16'h0020, 1'b0);
    core.strobe(1'b1, 1'b1, 8'h00);
    chk(nvm_mode_ctrl, MODE_BYTE);
    chk(data_rdata, 8'h66);
    chk({7'h00, busy}, 8'h01);
    core.settle();
    rd(16'h0020, 8'h66);
    // Reset in the middle of an erase, then a fresh program
    core.launch(MODE_ERASE, 8'h77, 16'h0000, 1'b0);
    repeat (4) @(negedge clock);
    rst_n = 0;
    repeat (2) @(negedge clock);
    chk(nvm_mode_ctrl, MODE_RESET);
    chk(data_rdata, DATA_RESET);
    chk({6'h00, busy, read_valid}, 8'h01);
    rst_n = 1;
    nb = 0;
    core.op(MODE_BYTE, 8'h5C, 16'h0030, 1'b0);
    chk(8'(nb), 8'(PROG_CYC));
    // Read result appears exactly two cycles after the load
    core.launch(MODE_BYTE, 8'h00, 16'h0030, 1'b1);
    chk({7'h00, read_valid}, 8'h00);
    @(negedge clock);
    chk(data_rdata, 8'h00);
    @(negedge clock);
    chk(data_rdata, 8'h5C);
    chk({7'h00, read_valid}, 8'h01);
    tally_and_finish();
  end
endmodule // test_nvm_byte_ctrl
